// ==== core/ssw_pkg.sv ====
// Shared constants for the supply supervisor and watchdog block.
// Assumes a single 125 MHz system clock drives every module.
package ssw_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_MHZ          = 125;
    localparam int unsigned WD_PERIOD_MS     = 1600;
    localparam int unsigned RST_PULSE_MS     = 200;
    localparam int unsigned WD_PERIOD_CYC    = WD_PERIOD_MS * 1000 * CLK_MHZ;
    localparam int unsigned RST_PULSE_CYC    = RST_PULSE_MS * 1000 * CLK_MHZ;
    localparam int unsigned CNT_W            = 32;

    // ==========================================================
    // Reset sequencer states
    // ==========================================================
    typedef enum logic [2:0] {
        ST_SUPPLY_LOW = 3'h1,
        ST_HOLD       = 3'h2,
        ST_RUN        = 3'h4
    } ssw_state_t;

    // ==========================================================
    // Output levels
    // ==========================================================
    localparam logic RST_ASSERTED_N = 1'b0;
    localparam logic SEL_MAIN       = 1'b0;
    localparam logic SEL_CELL       = 1'b1;

endpackage

// ==== core/ssw_sync.sv ====
// Two-stage synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/1ps
module ssw_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Data
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// ==== core/ssw_timer.sv ====
// Up-counter that flags when a terminal count is reached.
// Assumes the caller clears it whenever timing must restart.
`timescale 1ns/1ps
module ssw_timer #(
    parameter int unsigned LIMIT = 16
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Control
    input  wire logic clear_i,
    output logic      done_o
);
    logic [ssw_pkg::CNT_W-1:0] count;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= '0;
        end else if (clear_i) begin
            count <= '0;
        end else if (count != ssw_pkg::CNT_W'(LIMIT - 1)) begin
            count <= count + 1'b1;
        end
    end

    assign done_o = !clear_i && (count == ssw_pkg::CNT_W'(LIMIT - 1));
endmodule

// ==== core/ssw_top.sv ====
// Supply supervisor: watchdog, reset sequencer, power-fail flag, RAM supply select.
// Assumes comparator results arrive as asynchronous digital levels, high = condition true.
//
// How it works
// - Static toggle for full period triggers reset.
// - Any toggle edge or reset clears watchdog.
// - Watchdog cannot be disabled.
// - Expiry drives reset low one pulse length.
// - Hold reset while low, then 200 ms.
// - Active-high output is open-drain inverse.
// - Any supply dip restarts reset timing.
// - Watchdog cleared throughout reset, counts after.
// - Static toggle repeats pulses every period plus pulse.
// - Flag low on sense low or below switchover.
// - Below switchover, stay main until below cell.
// - Cell above supply, switch only below switchover.
// - Return to main when supply exceeds threshold.
`timescale 1ns/1ps
module ssw_top #(
    parameter int unsigned WD_CYC  = ssw_pkg::WD_PERIOD_CYC,
    parameter int unsigned RST_CYC = ssw_pkg::RST_PULSE_CYC
) (
    // Clock and reset
    input  wire logic CLOCK_I,
    input  wire logic RSTN_I,
    // Processor watchdog toggle
    input  wire logic WATCHDOG_TOGGLE_I,
    // Comparator results, high when the condition holds
    input  wire logic SUPPLY_BELOW_RESET_I,
    input  wire logic SUPPLY_BELOW_SWITCH_I,
    input  wire logic SUPPLY_BELOW_CELL_I,
    input  wire logic POWER_FAIL_SENSE_I,
    // Reset outputs
    output logic      RESET_OUT_N_O,
    output logic      RESET_HIGH_O,
    output logic      RESET_HIGH_OE_O,
    // Status and supply selection
    output logic      POWER_FAIL_FLAG_N_O,
    output logic      RAM_SUPPLY_CELL_O
);
    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic wdi_s;
    logic below_rst;
    logic below_sw;
    logic below_cell;
    logic sense_low;

    ssw_sync u_sync_wdi  (.clk_i(CLOCK_I), .rstn_i(RSTN_I), .d_i(WATCHDOG_TOGGLE_I),
                          .q_o(wdi_s));
    ssw_sync u_sync_rst  (.clk_i(CLOCK_I), .rstn_i(RSTN_I), .d_i(SUPPLY_BELOW_RESET_I),
                          .q_o(below_rst));
    ssw_sync u_sync_sw   (.clk_i(CLOCK_I), .rstn_i(RSTN_I), .d_i(SUPPLY_BELOW_SWITCH_I),
                          .q_o(below_sw));
    ssw_sync u_sync_cell (.clk_i(CLOCK_I), .rstn_i(RSTN_I), .d_i(SUPPLY_BELOW_CELL_I),
                          .q_o(below_cell));
    ssw_sync u_sync_pf   (.clk_i(CLOCK_I), .rstn_i(RSTN_I), .d_i(POWER_FAIL_SENSE_I),
                          .q_o(sense_low));

    // ==========================================================
    // Toggle edge detection
    // ==========================================================
    logic wdi_d;
    logic wdi_edge;

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wdi_d <= 1'b0;
        end else begin
            wdi_d <= wdi_s;
        end
    end

    assign wdi_edge = wdi_s ^ wdi_d;

    // ==========================================================
    // Reset sequencer
    // ==========================================================
    ssw_pkg::ssw_state_t state;
    ssw_pkg::ssw_state_t next_state;
    logic                hold_done;
    logic                wd_done;
    logic                hold_clear;
    logic                wd_clear;

    // The hold timer runs only in the hold state, so any dip restarts it.
    assign hold_clear = (state != ssw_pkg::ST_HOLD) || below_rst;
    // No enable exists: only reset or a toggle edge clears the watchdog.
    assign wd_clear   = (state != ssw_pkg::ST_RUN) || wdi_edge;

    ssw_timer #(.LIMIT(RST_CYC)) u_hold (
        .clk_i   (CLOCK_I),
        .rstn_i  (RSTN_I),
        .clear_i (hold_clear),
        .done_o  (hold_done)
    );

    ssw_timer #(.LIMIT(WD_CYC)) u_wd (
        .clk_i   (CLOCK_I),
        .rstn_i  (RSTN_I),
        .clear_i (wd_clear),
        .done_o  (wd_done)
    );

    always_comb begin
        next_state = state;
        case (state)
            ssw_pkg::ST_SUPPLY_LOW: begin
                if (!below_rst) begin
                    next_state = ssw_pkg::ST_HOLD;
                end
            end
            ssw_pkg::ST_HOLD: begin
                if (below_rst) begin
                    next_state = ssw_pkg::ST_SUPPLY_LOW;
                end else if (hold_done) begin
                    next_state = ssw_pkg::ST_RUN;
                end
            end
            ssw_pkg::ST_RUN: begin
                if (below_rst) begin
                    next_state = ssw_pkg::ST_SUPPLY_LOW;
                end else if (wd_done) begin
                    next_state = ssw_pkg::ST_HOLD;
                end
            end
            default: begin
                next_state = ssw_pkg::ST_SUPPLY_LOW;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state <= ssw_pkg::ST_SUPPLY_LOW;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Reset outputs
    // ==========================================================
    // The active-high pin is open drain: it is released, not driven, when asserted.
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RESET_OUT_N_O   <= ssw_pkg::RST_ASSERTED_N;
            RESET_HIGH_O    <= 1'b0;
            RESET_HIGH_OE_O <= 1'b0;
        end else begin
            RESET_OUT_N_O   <= (next_state == ssw_pkg::ST_RUN);
            RESET_HIGH_O    <= 1'b0;
            RESET_HIGH_OE_O <= (next_state == ssw_pkg::ST_RUN);
        end
    end

    // ==========================================================
    // Power-fail flag
    // ==========================================================
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            POWER_FAIL_FLAG_N_O <= 1'b0;
        end else begin
            POWER_FAIL_FLAG_N_O <= !(sense_low || below_sw);
        end
    end

    // ==========================================================
    // RAM supply selection
    // ==========================================================
    // Held in a flop so the source never changes inside a cycle.
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RAM_SUPPLY_CELL_O <= ssw_pkg::SEL_MAIN;
        end else if (!below_rst) begin
            RAM_SUPPLY_CELL_O <= ssw_pkg::SEL_MAIN;
        end else if (below_sw && below_cell) begin
            RAM_SUPPLY_CELL_O <= ssw_pkg::SEL_CELL;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    sequence expiry_s;
        state == ssw_pkg::ST_RUN && !below_rst && wd_done;
    endsequence

    sequence pulse_start_s;
        !RESET_OUT_N_O && RESET_HIGH_OE_O == 1'b0;
    endsequence

    property expiry_pulse_p;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        expiry_s |-> ##1 pulse_start_s;
    endproperty

    wd_expiry_reset_a: assert property (expiry_pulse_p)
        else $error("Watchdog expiry did not assert reset.");

    edge_clears_wd_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        wdi_edge |=> u_wd.count == '0)
        else $error("Watchdog count not cleared by a toggle edge.");

    no_wd_in_reset_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        !RESET_OUT_N_O |=> u_wd.count == '0)
        else $error("Watchdog counted during reset.");

    supply_low_reset_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        below_rst |-> ##1 !RESET_OUT_N_O)
        else $error("Reset not held while supply low.");

    dip_restarts_hold_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (state == ssw_pkg::ST_HOLD && below_rst) |-> ##1 state == ssw_pkg::ST_SUPPLY_LOW)
        else $error("Supply dip did not restart reset timing.");

    high_inverse_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        RESET_HIGH_OE_O == RESET_OUT_N_O && !RESET_HIGH_O)
        else $error("Active-high reset not inverse of low reset.");

    pf_flag_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (sense_low || below_sw) |=> !POWER_FAIL_FLAG_N_O)
        else $error("Power-fail flag not asserted.");

    main_above_rst_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        !below_rst |=> RAM_SUPPLY_CELL_O == ssw_pkg::SEL_MAIN)
        else $error("Supply select not main above reset threshold.");

    cell_needs_both_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        $rose(RAM_SUPPLY_CELL_O) |-> $past(below_sw && below_cell))
        else $error("Switched to cell without both conditions.");

    select_stable_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (below_rst && !(below_sw && below_cell)) |=> $stable(RAM_SUPPLY_CELL_O))
        else $error("Supply select changed without cause.");

    // Independent count of quiet cycles in the run state, so the expiry point is judged
    // against its own reckoning rather than against the timer's flag alone.
    logic [ssw_pkg::CNT_W-1:0] quiet_cnt;

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            quiet_cnt <= '0;
        end else if (state != ssw_pkg::ST_RUN || wdi_edge) begin
            quiet_cnt <= '0;
        end else begin
            quiet_cnt <= quiet_cnt + 1'b1;
        end
    end

    wd_timing_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        wd_done == (state == ssw_pkg::ST_RUN && !wdi_edge &&
                    quiet_cnt == ssw_pkg::CNT_W'(WD_CYC - 1)))
        else $error("Watchdog expiry not at the end of a quiet period.");

    hold_release_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (state == ssw_pkg::ST_HOLD && !below_rst && hold_done) |=>
        (RESET_OUT_N_O && RESET_HIGH_OE_O))
        else $error("Reset not released after the hold time.");

    release_after_hold_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        $rose(RESET_OUT_N_O) |-> $past(state == ssw_pkg::ST_HOLD && hold_done))
        else $error("Reset released before the hold time ended.");

    pf_clear_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (!sense_low && !below_sw) |=> POWER_FAIL_FLAG_N_O)
        else $error("Power-fail flag low without cause.");

    main_above_switch_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (!below_sw && RAM_SUPPLY_CELL_O == ssw_pkg::SEL_MAIN) |=>
        RAM_SUPPLY_CELL_O == ssw_pkg::SEL_MAIN)
        else $error("Switched to cell above the switchover level.");

    main_above_cell_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (!below_cell && RAM_SUPPLY_CELL_O == ssw_pkg::SEL_MAIN) |=>
        RAM_SUPPLY_CELL_O == ssw_pkg::SEL_MAIN)
        else $error("Switched to cell while supply above cell.");

    recovery_main_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (state == ssw_pkg::ST_SUPPLY_LOW && !below_rst) |=>
        (RAM_SUPPLY_CELL_O == ssw_pkg::SEL_MAIN && !RESET_OUT_N_O))
        else $error("Supply select not main at the start of the hold.");

    state_onehot_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        $onehot(state))
        else $error("Sequencer state is not one-hot.");
endmodule

// ==== tb/ssw_host.sv ====
// Host processor model that services the watchdog toggle input.
// Assumes it shares the device clock and sees the active-low reset output.
`timescale 1ns/1ps
module ssw_host #(
    parameter int unsigned GAP = 20
) (
    // Clock and device reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Control from the bench
    input  wire logic service_i,
    input  wire logic chatter_i,
    // Toggle to the device
    output logic      toggle_o
);
    int unsigned gap_cnt = 0;

    // ==========================================================
    // Toggle generation
    // ==========================================================
    // Chatter toggles every cycle while held in reset, which a real host would not do.
    initial toggle_o = 1'b0;
    always @(negedge clk_i) begin
        if (chatter_i && !reset_n_i) begin
            toggle_o <= ~toggle_o;
        end else if (!service_i || !reset_n_i) begin
            gap_cnt <= 0;
        end else if (gap_cnt == GAP - 1) begin
            gap_cnt  <= 0;
            toggle_o <= ~toggle_o;
        end else begin
            gap_cnt <= gap_cnt + 1;
        end
    end
endmodule

// ==== tb/supply_supervisor_watchdog_reset_test.sv ====
// Self-checking bench for the supply supervisor with a host model on the toggle.
// Assumes comparator inputs are positive-true levels synchronised inside the design.
`timescale 1ns/1ps
module supply_supervisor_watchdog_reset_test;
    // ==========================================================
    // Signals
    // ==========================================================
    localparam int unsigned WD = 40;
    localparam int unsigned RS = 10;
    // Each step is sense, below reset, below switch, below cell, then select and flag.
    localparam logic [5:0] STEPS [7] = '{6'h15, 6'h18, 6'h1e, 6'h17, 6'h01, 6'h20, 6'h01};
    logic clk, rstn, below_rst, below_sw, below_cell, sense, service, chatter;
    logic toggle, rst_n, rst_hi, rst_oe, pf_n, sel_cell;
    int   fails = 0;
    int   total_checks = 0;
    int   cycles = 0;
    int   n;

    ssw_top #(.WD_CYC(WD), .RST_CYC(RS)) u_dut (
        .CLOCK_I(clk), .RSTN_I(rstn), .WATCHDOG_TOGGLE_I(toggle),
        .SUPPLY_BELOW_RESET_I(below_rst), .SUPPLY_BELOW_SWITCH_I(below_sw),
        .SUPPLY_BELOW_CELL_I(below_cell), .POWER_FAIL_SENSE_I(sense),
        .RESET_OUT_N_O(rst_n), .RESET_HIGH_O(rst_hi), .RESET_HIGH_OE_O(rst_oe),
        .POWER_FAIL_FLAG_N_O(pf_n), .RAM_SUPPLY_CELL_O(sel_cell)
    );
    ssw_host #(.GAP(20)) u_host (
        .clk_i(clk), .reset_n_i(rst_n), .service_i(service), .chatter_i(chatter),
        .toggle_o(toggle)
    );

    initial clk = 1'b0;
    always #4 clk = ~clk;

    // The run needs well under a thousand cycles, so this only cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_rst(input logic lvl);
        n = 0;
        while (rst_n !== lvl && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic in_range(input string name, input int lo, input int hi);
        check(name, {7'h0, n >= lo && n <= hi}, 8'h1);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_power_up();
        repeat (5) @(negedge clk);
        check("in reset", {3'h0, rst_n, rst_oe, rst_hi, pf_n, sel_cell}, 8'h0);
        rstn = 1'b1;
        wait_rst(1'b1);
        in_range("power-up hold", RS + 1, RS + 5);
        check("open drain", {6'h0, rst_oe, rst_hi}, 8'h2);
        $display("test power_up done");
    endtask

    task automatic t_serviced();
        int lows = 0;
        repeat (6 * WD) begin
            @(negedge clk);
            if (rst_n !== 1'b1) lows++;
        end
        check("serviced lows", 8'(lows), 8'h0);
        $display("test serviced done");
    endtask

    task automatic t_expiry();
        service = 1'b0;
        wait_rst(1'b0);
        in_range("first expiry", 1, WD + 4);
        wait_rst(1'b1);
        in_range("pulse length", RS - 1, RS + 1);
        wait_rst(1'b0);
        in_range("static repeat", WD, WD + 3);
        chatter = 1'b1;
        repeat (RS - 4) @(negedge clk);
        chatter = 1'b0;
        check("reset while chatter", {7'h0, rst_n}, 8'h0);
        wait_rst(1'b1);
        wait_rst(1'b0);
        in_range("count after chatter", WD, WD + 3);
        service = 1'b1;
        wait_rst(1'b1);
        $display("test expiry done");
    endtask

    task automatic t_supply_dip();
        {below_rst, below_sw, below_cell} = 3'h7;
        repeat (4) @(negedge clk);
        check("dip outputs", {5'h0, rst_n, pf_n, sel_cell}, 8'h1);
        {below_rst, below_sw, below_cell} = 3'h0;
        repeat (4) @(negedge clk);
        check("early main", {6'h0, rst_n, sel_cell}, 8'h0);
        below_rst = 1'b1;
        repeat (3) @(negedge clk);
        below_rst = 1'b0;
        wait_rst(1'b1);
        in_range("restarted hold", RS + 1, RS + 5);
        $display("test supply_dip done");
    endtask

    task automatic t_select();
        for (int i = 0; i < 7; i++) begin
            {sense, below_rst, below_sw, below_cell} = STEPS[i][5:2];
            repeat (4) @(negedge clk);
            check("ram select", {7'h0, sel_cell}, {7'h0, STEPS[i][1]});
            check("power-fail flag", {7'h0, pf_n}, {7'h0, STEPS[i][0]});
        end
        wait_rst(1'b1);
        $display("test select done");
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {rstn, below_rst, below_sw, below_cell, sense, chatter} = 6'h0;
        service = 1'b1;
        t_power_up();
        t_serviced();
        t_expiry();
        t_supply_dip();
        t_select();
        complete_run();
    end
endmodule
